// ---- core/usb_phy_resume_regs.svh ----
`ifndef USB_PHY_RESUME_REGS_SVH
`define USB_PHY_RESUME_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PWR_SIG_OFS       8'h3C
`define XCVR_CTRL_OFS     8'h40
`define IRQ_STAT_OFS      8'h44
`define IRQ_MASK_OFS      8'h48
`define LINE_STAT_OFS     8'h4C

// ****************************************
// Field positions
// ****************************************
`define PS_VALID_BIT      8
`define PS_DATA_MSB       7
`define PULLDN_OFF_BIT    18
`define RST_CAUSE_BIT     13
`define RES_CAUSE_BIT     12
`define FILT_MSB          11
`define FILT_LSB          8
`define HW_RESUME_BIT     7
`define CONF_MSB          6
`define CONF_LSB          4
`define EV_J_BIT          0
`define EV_K_BIT          1
`define EV_SE0_BIT        2
`define EV_RESUME_BIT     3

// ****************************************
// Reset values and writable masks
// ****************************************
`define PWR_SIG_RST       32'h0000_0000
`define XCVR_CTRL_RST     32'h0000_0000
`define IRQ_RST           4'h0
`define PWR_SIG_WMASK     32'h0000_01FF
`define XCVR_CTRL_WMASK   32'h0004_3FF0
`define FILT_CNT_ONE      16'h0001

`endif

// ---- core/usb_phy_resume_pkg.sv ----
package usb_phy_resume_pkg;
    typedef enum logic [1:0] {
        SYM_SE0 = 2'h0,
        SYM_J   = 2'h1,
        SYM_K   = 2'h2,
        SYM_SE1 = 2'h3
    } line_sym_e;

    typedef enum logic {
        BUS_ACTIVE,
        BUS_SUSPENDED
    } susp_state_e;
endpackage : usb_phy_resume_pkg

// ---- core/line_filter_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface line_filter_if;
    logic [1:0] raw_state;
    logic [3:0] log2_clks;
    logic [1:0] filt_state;

    modport ctrl (output raw_state, output log2_clks, input filt_state);
    modport filt (input raw_state, input log2_clks, output filt_state);
endinterface : line_filter_if
`default_nettype wire

// ---- core/line_state_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "usb_phy_resume_regs.svh"
module line_state_filter (
    input  wire logic    i_sys_clk,
    input  wire logic    i_reset_n,
    line_filter_if.filt  lf
);
    logic [1:0]  cand_reg;
    logic [1:0]  filt_reg;
    logic [15:0] cnt_reg;
    logic [15:0] lim_m1;

    // Cycles a new state must stand, less one
    assign lim_m1 = (`FILT_CNT_ONE << lf.log2_clks) - `FILT_CNT_ONE;
    assign lf.filt_state = filt_reg;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cand_reg <= 2'h1;
            cnt_reg  <= 16'h0000;
        end else if (lf.raw_state != cand_reg) begin
            cand_reg <= lf.raw_state;
            cnt_reg  <= 16'h0000;
        // Ordered compare: a lowered field must not let the count wrap
        end else if (cand_reg != filt_reg && cnt_reg < lim_m1) begin
            cnt_reg  <= cnt_reg + `FILT_CNT_ONE;
        end
    end

    // Idle bus is J, so start there rather than report a false SE0
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            filt_reg <= 2'h1;
        end else if (lf.raw_state == cand_reg && cand_reg != filt_reg
                     && cnt_reg >= lim_m1) begin
            filt_reg <= cand_reg;
        end
    end

    filt_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (filt_reg != $past(filt_reg)) |->
            ($past(cnt_reg) >= $past(lim_m1)
             && $past(cand_reg) == filt_reg))
        else $error("Line state passed before hold time");
endmodule : line_state_filter
`default_nettype wire

// ---- core/usb_phy_resume_control.sv ----
// What this block does
// - A line state change reaches the filtered output only after it has stood for two to the power of the filter field, in clocks.
// - An automatic resume caused by SE0 sets the reset-cause flag at bit 13, which holds until software writes zero.
// - An automatic resume caused by K sets the resume-cause flag at bit 12, which holds until software writes zero.
// - With bit 7 set the suspend logic resumes in hardware; with it clear software polls the filtered line state.
// - The three transceiver configuration pins follow bits 6 to 4 of the transceiver control register.
// - Bit 18 set turns off the pulldowns on both pulldown ports; it resets to zero, pulldowns on.
// - Separate flags are set when the filtered line state shows J, K or SE0.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "usb_phy_resume_regs.svh"
module usb_phy_resume_control (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [1:0]  i_line_state,
    input  wire logic        i_suspend,
    output logic             o_auto_resume,
    output logic      [1:0]  o_line_state_filt,
    output logic      [2:0]  o_transceiver_config_pins,
    output logic             o_first_pulldown_port_off,
    output logic             o_second_pulldown_port_off,
    output logic             o_power_valid,
    output logic      [7:0]  o_power_data,
    output logic             o_irq
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0] pwr_reg;
    logic [31:0] ctrl_reg;
    logic [3:0]  stat_reg;
    logic [3:0]  stat_next;
    logic [3:0]  mask_reg;
    logic [1:0]  ls_meta_reg;
    logic [1:0]  ls_sync_reg;
    logic [1:0]  filt_prev_reg;
    logic        resume_reg;
    logic        wr_pwr;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_mask;
    logic        enter_j;
    logic        enter_k;
    logic        enter_se0;
    logic        res_k;
    logic        res_se0;
    logic [3:0]  events;
    logic [31:0] rd_mux;
    usb_phy_resume_pkg::susp_state_e state_reg;
    line_filter_if lf ();

    // ****************************************
    // Pin synchroniser and filter
    // ****************************************
    // Line state is asynchronous to the system clock
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ls_meta_reg <= 2'h1;
            ls_sync_reg <= 2'h1;
        end else begin
            ls_meta_reg <= i_line_state;
            ls_sync_reg <= ls_meta_reg;
        end
    end

    assign lf.raw_state = ls_sync_reg;
    assign lf.log2_clks = ctrl_reg[`FILT_MSB:`FILT_LSB];

    line_state_filter u_filter (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .lf        (lf.filt)
    );

    assign o_line_state_filt = lf.filt_state;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            filt_prev_reg <= 2'h1;
        end else begin
            filt_prev_reg <= lf.filt_state;
        end
    end

    // Flag on entry so a held symbol can still be cleared
    assign enter_j   = lf.filt_state != filt_prev_reg
                       && lf.filt_state == usb_phy_resume_pkg::SYM_J;
    assign enter_k   = lf.filt_state != filt_prev_reg
                       && lf.filt_state == usb_phy_resume_pkg::SYM_K;
    assign enter_se0 = lf.filt_state != filt_prev_reg
                       && lf.filt_state == usb_phy_resume_pkg::SYM_SE0;

    // ****************************************
    // Bus decode
    // ****************************************
    assign wr_pwr  = i_wr && i_addr == `PWR_SIG_OFS;
    assign wr_ctrl = i_wr && i_addr == `XCVR_CTRL_OFS;
    assign wr_stat = i_wr && i_addr == `IRQ_STAT_OFS;
    assign wr_mask = i_wr && i_addr == `IRQ_MASK_OFS;

    // ****************************************
    // Suspend and resume
    // ****************************************
    // Hardware resume only when enabled; otherwise software polls
    assign res_k   = state_reg == usb_phy_resume_pkg::BUS_SUSPENDED
                     && ctrl_reg[`HW_RESUME_BIT] && enter_k;
    assign res_se0 = state_reg == usb_phy_resume_pkg::BUS_SUSPENDED
                     && ctrl_reg[`HW_RESUME_BIT] && enter_se0;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= usb_phy_resume_pkg::BUS_ACTIVE;
        end else begin
            unique case (state_reg)
                usb_phy_resume_pkg::BUS_ACTIVE: begin
                    if (i_suspend) begin
                        state_reg <= usb_phy_resume_pkg::BUS_SUSPENDED;
                    end
                end
                usb_phy_resume_pkg::BUS_SUSPENDED: begin
                    if (!i_suspend || res_k || res_se0) begin
                        state_reg <= usb_phy_resume_pkg::BUS_ACTIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= res_k || res_se0;
        end
    end

    assign o_auto_resume = resume_reg;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwr_reg <= `PWR_SIG_RST;
        end else if (wr_pwr) begin
            pwr_reg <= i_wdata & `PWR_SIG_WMASK;
        end
    end

    // Cause flags: hardware set wins over a software clear
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= `XCVR_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_wdata & `XCVR_CTRL_WMASK;
            end
            if (res_se0) begin
                ctrl_reg[`RST_CAUSE_BIT] <= 1'b1;
            end
            if (res_k) begin
                ctrl_reg[`RES_CAUSE_BIT] <= 1'b1;
            end
        end
    end

    assign o_transceiver_config_pins =
        ctrl_reg[`CONF_MSB:`CONF_LSB];
    assign o_first_pulldown_port_off  = ctrl_reg[`PULLDN_OFF_BIT];
    assign o_second_pulldown_port_off = ctrl_reg[`PULLDN_OFF_BIT];
    assign o_power_valid = pwr_reg[`PS_VALID_BIT];
    assign o_power_data  = pwr_reg[`PS_DATA_MSB:0];

    // ****************************************
    // Interrupts
    // ****************************************
    always_comb begin
        events = 4'h0;
        events[`EV_J_BIT]      = enter_j;
        events[`EV_K_BIT]      = enter_k;
        events[`EV_SE0_BIT]    = enter_se0;
        events[`EV_RESUME_BIT] = res_k || res_se0;
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~i_wdata[3:0];
        end
        stat_next = stat_next | events;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_reg <= `IRQ_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_reg <= `IRQ_RST;
        end else if (wr_mask) begin
            mask_reg <= i_wdata[3:0];
        end
    end

    assign o_irq = |(stat_reg & mask_reg);

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_addr)
            `PWR_SIG_OFS:   rd_mux = pwr_reg;
            `XCVR_CTRL_OFS: rd_mux = ctrl_reg;
            `IRQ_STAT_OFS:  rd_mux = {28'h000_0000, stat_reg};
            `IRQ_MASK_OFS:  rd_mux = {28'h000_0000, mask_reg};
            `LINE_STAT_OFS: rd_mux = {30'h0, lf.filt_state};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // Data only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= rd_mux;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    conf_pins_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_ctrl |=> o_transceiver_config_pins == $past(i_wdata[6:4]))
        else $error("Config pins do not follow register");

    pulldown_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_ctrl |=> o_first_pulldown_port_off == $past(i_wdata[18])
                 && o_second_pulldown_port_off == $past(i_wdata[18]))
        else $error("Pulldown control wrong");

    reset_cause_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        res_se0 |=> ctrl_reg[13] && o_auto_resume)
        else $error("Reset cause flag not set");

    resume_cause_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        res_k |=> ctrl_reg[12] && o_auto_resume)
        else $error("Resume cause flag not set");

    cause_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        ctrl_reg[13] && !wr_ctrl |=> ctrl_reg[13])
        else $error("Reset cause flag lost");

    sw_resume_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !ctrl_reg[7] |=> !o_auto_resume)
        else $error("Hardware resume while disabled");

    line_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        enter_k |=> stat_reg[1] ##1 (stat_reg[1] || $past(wr_stat)))
        else $error("K flag not set");

    reserved_zero_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_rd && i_addr == `XCVR_CTRL_OFS |=>
            o_rdata[31:19] == 13'h0 && o_rdata[17:14] == 4'h0
            && o_rdata[3:0] == 4'h0)
        else $error("Reserved bits not zero");

    irq_level_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(stat_reg[3]) && mask_reg[3] |-> o_irq)
        else $error("Interrupt not raised");

    rdata_idle_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("Read data left standing");

    pwr_rsvd_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_rd && i_addr == `PWR_SIG_OFS |=> o_rdata[31:9] == 23'h0)
        else $error("Power register reserved bits not zero");

    power_out_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pwr |=> o_power_valid == $past(i_wdata[`PS_VALID_BIT])
                && o_power_data == $past(i_wdata[`PS_DATA_MSB:0]))
        else $error("Power outputs do not follow register");

    auto_pulse_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_auto_resume |=> !o_auto_resume)
        else $error("Resume pulse longer than one cycle");

    active_resume_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        state_reg == usb_phy_resume_pkg::BUS_ACTIVE |=> !o_auto_resume)
        else $error("Resume outside suspend");

    resume_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        res_k || res_se0 |=> stat_reg[`EV_RESUME_BIT])
        else $error("Resume status flag not set");

    se0_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        enter_se0 |=> stat_reg[`EV_SE0_BIT])
        else $error("SE0 flag not set");

    j_flag_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        stat_reg[`EV_J_BIT] && !wr_stat |=> stat_reg[`EV_J_BIT])
        else $error("J flag lost");

    w1c_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_stat && i_wdata[`EV_SE0_BIT] && !enter_se0
            |=> !stat_reg[`EV_SE0_BIT])
        else $error("SE0 flag not cleared");

    resume_k_c: cover property (
        @(posedge i_sys_clk) disable iff (!i_reset_n) res_k);
    resume_se0_c: cover property (
        @(posedge i_sys_clk) disable iff (!i_reset_n) res_se0);
    irq_c: cover property (
        @(posedge i_sys_clk) disable iff (!i_reset_n) $rose(o_irq));
    soft_poll_c: cover property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        enter_k && !ctrl_reg[`HW_RESUME_BIT]
        && state_reg == usb_phy_resume_pkg::BUS_SUSPENDED);
    cause_clr_c: cover property (
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_ctrl && ctrl_reg[`RES_CAUSE_BIT] && !i_wdata[`RES_CAUSE_BIT]);
endmodule : usb_phy_resume_control
`default_nettype wire

// ---- verification/usb_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Bus line partner: raw J/K/SE0 at the pin
// ****************************************
module usb_line_model (
    input  wire logic       i_sys_clk,
    output logic      [1:0] o_line_state
);
    // Idle bus rests in J, as a pulled-up full-speed line does
    initial o_line_state = usb_phy_resume_pkg::SYM_J;

    // Changes right after an edge so the sync flops never race the bench
    task automatic send(input logic [1:0] sym, input int unsigned hold);
        @(posedge i_sys_clk);
        o_line_state <= sym;
        repeat (hold) @(posedge i_sys_clk);
        #1;
    endtask : send
endmodule : usb_line_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "usb_phy_resume_regs.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module tb;
    // ****************************************
    // Clock, reset and ports
    // ****************************************
    logic        i_sys_clk;
    logic        i_reset_n;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic        i_suspend;
    logic [31:0] o_rdata;
    logic [1:0]  line;
    logic        o_auto_resume;
    logic [1:0]  filt;
    logic [2:0]  cfg;
    logic        pd_a;
    logic        pd_b;
    logic        pwr_valid;
    logic [7:0]  pwr_data;
    logic        o_irq;
    int          bad_count;
    int          tests_run;
    int          cyc;

    usb_line_model u_line (.i_sys_clk(i_sys_clk), .o_line_state(line));

    usb_phy_resume_control u_dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_line_state(line), .i_suspend(i_suspend),
        .o_auto_resume(o_auto_resume), .o_line_state_filt(filt),
        .o_transceiver_config_pins(cfg), .o_first_pulldown_port_off(pd_a),
        .o_second_pulldown_port_off(pd_b), .o_power_valid(pwr_valid),
        .o_power_data(pwr_data), .o_irq(o_irq));

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // Generous ceiling; the whole run needs a few hundred cycles
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(nm, e, o_rdata)
    endtask : rd

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        rd(`PWR_SIG_OFS, 32'h0000_0000, "pwr rst");
        rd(`XCVR_CTRL_OFS, 32'h0000_0000, "ctrl rst");
        rd(`IRQ_STAT_OFS, 32'h0000_0000, "stat rst");
        rd(`IRQ_MASK_OFS, 32'h0000_0000, "mask rst");
        rd(`LINE_STAT_OFS, 32'h0000_0001, "line rst");
        `CHK("pd rst", 2'h0, {pd_a, pd_b})
        `CHK("irq rst", 1'b0, o_irq)
    endtask : test_reset

    task automatic test_regs();
        wr(`PWR_SIG_OFS, 32'hFFFF_FFFF);
        rd(`PWR_SIG_OFS, 32'h0000_01FF, "pwr rsvd");
        `CHK("pwr out", 9'h1FF, {pwr_valid, pwr_data})
        wr(`XCVR_CTRL_OFS, 32'hFFFF_FFFF);
        rd(`XCVR_CTRL_OFS, 32'h0004_3FF0, "ctrl rsvd");
        `CHK("pd off", 2'h3, {pd_a, pd_b})
        for (int i = 0; i < 8; i++) begin
            wr(`XCVR_CTRL_OFS, 32'(i) << 4);
            `CHK("cfg pins", 3'(i), cfg)
        end
        `CHK("pd on", 2'h0, {pd_a, pd_b})
        wr(8'h50, 32'hFFFF_FFFF);
        rd(8'h50, 32'h0000_0000, "unmapped");
        wr(`PWR_SIG_OFS, 32'h0000_0000);
    endtask : test_regs

    task automatic test_filter(input int n);
        int c;
        int lim;
        c = 0;
        lim = 1 << n;
        wr(`XCVR_CTRL_OFS, 32'(n) << 8);
        if (n == 2) begin
            // Glitch one clock short of the hold time must be dropped
            wr(`IRQ_STAT_OFS, 32'h0000_000F);
            u_line.send(usb_phy_resume_pkg::SYM_K, 3);
            u_line.send(usb_phy_resume_pkg::SYM_J, 12);
            `CHK("glitch", usb_phy_resume_pkg::SYM_J, filt)
            rd(`IRQ_STAT_OFS, 32'h0000_0000, "glitch flag");
        end
        u_line.send(usb_phy_resume_pkg::SYM_K, 0);
        while (filt !== usb_phy_resume_pkg::SYM_K && c < 100) begin
            @(posedge i_sys_clk);
            #1;
            c++;
        end
        `CHK("filt early", 1'b1, c >= lim + 2)
        `CHK("filt late", 1'b1, c <= lim + 4)
        u_line.send(usb_phy_resume_pkg::SYM_J, lim + 8);
    endtask : test_filter

    task automatic test_flags();
        logic [1:0] sym [3];
        logic [3:0] bit_of [3];
        sym = '{usb_phy_resume_pkg::SYM_K, usb_phy_resume_pkg::SYM_SE0,
                usb_phy_resume_pkg::SYM_J};
        bit_of = '{4'h2, 4'h4, 4'h1};
        wr(`XCVR_CTRL_OFS, 32'h0000_0000);
        wr(`IRQ_STAT_OFS, 32'h0000_000F);
        for (int i = 0; i < 3; i++) begin
            u_line.send(sym[i], 8);
            rd(`IRQ_STAT_OFS, 32'(bit_of[i]), "line flag");
            `CHK("irq masked", 1'b0, o_irq)
            wr(`IRQ_MASK_OFS, 32'(bit_of[i]));
            `CHK("irq on", 1'b1, o_irq)
            wr(`IRQ_STAT_OFS, 32'(bit_of[i]));
            `CHK("irq clr", 1'b0, o_irq)
            rd(`IRQ_STAT_OFS, 32'h0000_0000, "w1c");
        end
        wr(`IRQ_MASK_OFS, 32'h0000_0000);
    endtask : test_flags

    task automatic test_resume(input logic [31:0] ctl, input logic [1:0] sym,
                               input int pulses, input logic [31:0] ctl_e,
                               input logic [31:0] st_e);
        int seen;
        seen = 0;
        wr(`XCVR_CTRL_OFS, ctl);
        u_line.send(usb_phy_resume_pkg::SYM_J, 8);
        wr(`IRQ_STAT_OFS, 32'h0000_000F);
        @(posedge i_sys_clk);
        i_suspend <= 1'b1;
        u_line.send(sym, 0);
        repeat (20) begin
            @(posedge i_sys_clk);
            #1;
            if (o_auto_resume === 1'b1) seen++;
        end
        `CHK("resume pulse", pulses, seen)
        rd(`XCVR_CTRL_OFS, ctl_e, "cause bit");
        rd(`IRQ_STAT_OFS, st_e, "resume stat");
        rd(`LINE_STAT_OFS, 32'(sym), "polled line");
        wr(`XCVR_CTRL_OFS, ctl);
        rd(`XCVR_CTRL_OFS, ctl, "cause clr");
        @(posedge i_sys_clk);
        i_suspend <= 1'b0;
    endtask : test_resume

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        bad_count = 0;
        tests_run = 0;
        cyc = 0;
        i_reset_n = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_suspend = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        test_reset();
        test_regs();
        test_filter(0);
        test_filter(2);
        test_filter(3);
        test_flags();
        test_resume(32'h80, usb_phy_resume_pkg::SYM_K, 1, 32'h1080, 32'hA);
        test_resume(32'h80, usb_phy_resume_pkg::SYM_SE0, 1, 32'h2080, 32'hC);
        test_resume(32'h00, usb_phy_resume_pkg::SYM_K, 0, 32'h0000, 32'h2);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
